// ---- core/ir_ctrl_pkg.sv ----
// Functional notes
// - Programming pulse no longer than 5 us
// - MIR/FIR: shutdown high, wait, tx high, lower
// - Hold tx or shutdown 50 ns after latch
// - SIR: shutdown high, tx low, then lower
// - Tx high 200 ns in pulse enables remote
// - Never drive both transmit inputs high together
package ir_ctrl_pkg;
	localparam int unsigned CLK_NS             = 10;
	localparam int unsigned SHUTDOWN_PULSE_US  = 30;
	localparam int unsigned PROGRAM_SETUP_NS   = 200;
	localparam int unsigned REMOTE_PULSE_NS    = 200;
	localparam int unsigned RATE_SETUP_NS      = 50;
	localparam int unsigned LATCH_HOLD_NS      = 50;
	localparam int unsigned PROGRAM_MAX_NS     = 5000;
	// Least times round up
	localparam int unsigned SHUTDOWN_CYC = (SHUTDOWN_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SETUP_CYC    = (PROGRAM_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned REMOTE_CYC   = (REMOTE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned RATE_CYC     = (RATE_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned HOLD_CYC     = (LATCH_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PROG_MAX_CYC = PROGRAM_MAX_NS / CLK_NS;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	// Ctrl fields
	localparam int unsigned CTRL_CMD_LSB  = 0;
	localparam int unsigned CTRL_GO_BIT   = 4;
	localparam int unsigned CTRL_IRDA_BIT = 8;
	localparam int unsigned CTRL_RC_BIT   = 9;
	localparam int unsigned CTRL_DIR_BIT  = 10;
	// Commands
	localparam logic [1:0] CMD_SIR      = 2'h0;
	localparam logic [1:0] CMD_FIR      = 2'h1;
	localparam logic [1:0] CMD_REMOTE   = 2'h2;
	localparam logic [1:0] CMD_SHUTDOWN = 2'h3;
	// Device mode as tracked here
	localparam logic [1:0] MODE_SIR    = 2'h0;
	localparam logic [1:0] MODE_FIR    = 2'h1;
	localparam logic [1:0] MODE_REMOTE = 2'h2;
	localparam logic [1:0] MODE_OFF    = 2'h3;
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_TXSET, ST_HOLD, ST_SHUT} seq_t;
endpackage

// ---- core/ir_ctrl.sv ----
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ir_ctrl
	import ir_ctrl_pkg::*;
#(
	parameter int unsigned SHUTDOWN_CYCLES = SHUTDOWN_CYC
)(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Device pins
	output logic             shutdown_program_in,
	output logic             irda_tx_in,
	output logic             remote_tx_in
);
	import ir_ctrl_pkg::*;

	localparam int unsigned CW = 16;

	logic        wr_pend_ff;
	logic        rd_sel_ff;
	logic [7:0]  addr_ff;
	logic [1:0]  cmd_ff;
	logic        go_ff;
	logic        irda_data_ff;
	logic        rc_data_ff;
	logic        direct_ff;
	logic [1:0]  mode_ff;
	seq_t        state_ff;
	logic [CW-1:0] cnt_ff;
	logic        busy;
	logic        cnt_done;
	logic [CW-1:0] shut_len;

	assign busy     = (state_ff != ST_IDLE);
	assign cnt_done = (cnt_ff == '0);
	assign shut_len = CW'(SHUTDOWN_CYCLES);

	// Bus address phase capture; zero wait states
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff <= 1'b0;
			rd_sel_ff  <= 1'b0;
			addr_ff    <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_ff <= hsel & htrans[1] & hwrite;
			rd_sel_ff  <= hsel & htrans[1] & ~hwrite;
			addr_ff    <= haddr[7:0];
		end
		else
		begin
			wr_pend_ff <= 1'b0;
			rd_sel_ff  <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data registered in address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (hready && hsel && htrans[1] && !hwrite)
		begin
			unique case (haddr[7:0])
				CTRL_OFS:
					hrdata <= {21'h0, direct_ff, rc_data_ff, irda_data_ff, 3'h0, go_ff, 2'h0, cmd_ff};
				STATUS_OFS:
					hrdata <= {29'h0, mode_ff, busy};
				default:
					hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Control register and start strobe
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cmd_ff       <= CMD_SIR;
			go_ff        <= 1'b0;
			irda_data_ff <= 1'b0;
			rc_data_ff   <= 1'b0;
			direct_ff    <= 1'b0;
		end
		else if (wr_pend_ff && addr_ff == CTRL_OFS)
		begin
			// Command frozen while a sequence starts or runs
			if (!busy && !go_ff)
				cmd_ff <= hwdata[CTRL_CMD_LSB +: 2];
			go_ff        <= hwdata[CTRL_GO_BIT] & ~busy & ~go_ff;
			irda_data_ff <= hwdata[CTRL_IRDA_BIT];
			rc_data_ff   <= hwdata[CTRL_RC_BIT];
			direct_ff    <= hwdata[CTRL_DIR_BIT];
		end
		else
			go_ff <= 1'b0;
	end

	// Programming sequencer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff <= ST_IDLE;
			cnt_ff   <= '0;
		end
		else
		begin
			unique case (state_ff)
				ST_IDLE:
					if (go_ff)
					begin
						if (cmd_ff == CMD_SHUTDOWN)
						begin
							state_ff <= ST_SHUT;
							cnt_ff   <= shut_len;
						end
						else
						begin
							state_ff <= ST_SETUP;
							cnt_ff   <= CW'(SETUP_CYC - 1);
						end
					end
				ST_SETUP:
					if (cnt_done)
					begin
						state_ff <= ST_TXSET;
						// Remote needs the longer tx pulse
						cnt_ff   <= (cmd_ff == CMD_REMOTE) ? CW'(REMOTE_CYC) : CW'(RATE_CYC);
					end
					else
						cnt_ff <= cnt_ff - 1'b1;
				ST_TXSET:
					if (cnt_done)
					begin
						state_ff <= ST_HOLD;
						cnt_ff   <= CW'(HOLD_CYC);
					end
					else
						cnt_ff <= cnt_ff - 1'b1;
				ST_HOLD, ST_SHUT:
					if (cnt_done)
						state_ff <= ST_IDLE;
					else
						cnt_ff <= cnt_ff - 1'b1;
			endcase
		end
	end

	// Tracked device setting
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mode_ff <= MODE_SIR;
		else if (state_ff == ST_SHUT && cnt_done)
			mode_ff <= MODE_SIR;
		else if (state_ff == ST_TXSET && cnt_done)
			mode_ff <= (cmd_ff == CMD_FIR) ? MODE_FIR : ((cmd_ff == CMD_REMOTE) ? MODE_REMOTE : MODE_SIR);
		else if (state_ff == ST_SHUT)
			mode_ff <= MODE_OFF;
	end

	// Pin drive
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			shutdown_program_in <= 1'b0;
			irda_tx_in          <= 1'b0;
			remote_tx_in        <= 1'b0;
		end
		else
		begin
			unique case (state_ff)
				ST_IDLE:
				begin
					shutdown_program_in <= go_ff;
					irda_tx_in          <= go_ff ? 1'b0 : irda_data_ff;
					// Two-pin drive never raises both inputs
					remote_tx_in        <= go_ff ? 1'b0 : (direct_ff & rc_data_ff & ~irda_data_ff);
				end
				ST_SETUP:
				begin
					shutdown_program_in <= 1'b1;
					irda_tx_in          <= cnt_done && (cmd_ff != CMD_SIR);
					remote_tx_in        <= 1'b0;
				end
				ST_TXSET:
				begin
					// Falling edge latches tx level
					shutdown_program_in <= ~cnt_done;
					irda_tx_in          <= (cmd_ff != CMD_SIR);
					remote_tx_in        <= 1'b0;
				end
				ST_HOLD:
				begin
					shutdown_program_in <= 1'b0;
					irda_tx_in          <= cnt_done ? irda_data_ff : (cmd_ff != CMD_SIR);
					remote_tx_in        <= 1'b0;
				end
				ST_SHUT:
				begin
					shutdown_program_in <= ~cnt_done;
					irda_tx_in          <= 1'b0;
					remote_tx_in        <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- testbench/ir_ctrl_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module ir_ctrl_checker
	import ir_ctrl_pkg::*;
#(parameter int unsigned SHUTDOWN_CYCLES = SHUTDOWN_CYC)(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic shutdown_program_in,
	input wire logic irda_tx_in,
	input wire logic remote_tx_in
);
	int unsigned hi_ff;
	int unsigned st_ff;
	// Cycles with the shutdown pin high, cycles since the irda pin moved
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			hi_ff <= 0;
		else
			hi_ff <= shutdown_program_in ? hi_ff + 1 : 0;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			st_ff <= 0;
		else
			st_ff <= $changed(irda_tx_in) ? 0 : st_ff + 1;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_pulse_len: assert property ($fell(shutdown_program_in) |->
		hi_ff <= PROG_MAX_CYC || hi_ff >= SHUTDOWN_CYCLES)
		else $error("shutdown pin pulse length");
	a_setup_wait: assert property ($rose(irda_tx_in) && shutdown_program_in |-> hi_ff >= SETUP_CYC)
		else $error("irda raised too early");
	a_rate_setup: assert property ($fell(shutdown_program_in) |-> st_ff + 1 >= RATE_CYC)
		else $error("irda not settled before latch");
	a_latch_hold: assert property ($fell(shutdown_program_in) && hi_ff < SHUTDOWN_CYCLES |->
		$stable(irda_tx_in)[*5])
		else $error("irda moved after latch");
	a_remote_width: assert property ($fell(irda_tx_in) && shutdown_program_in &&
		$past(shutdown_program_in) |-> st_ff + 1 >= REMOTE_CYC)
		else $error("short irda pulse in program");
	a_no_both: assert property (!(irda_tx_in && remote_tx_in))
		else $error("both transmit pins high");
	cover property ($fell(shutdown_program_in) && irda_tx_in);
	cover property ($fell(shutdown_program_in) && !irda_tx_in);
	cover property ($fell(shutdown_program_in) && hi_ff >= SHUTDOWN_CYCLES);
	cover property (remote_tx_in);
endmodule
`default_nettype wire

// ---- testbench/ir_dev_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ir_dev_model
	import ir_ctrl_pkg::*;
#(parameter int unsigned SHUT_NS = SHUTDOWN_PULSE_US * 1000)(
	input wire logic  shutdown_program_in,
	input wire logic  irda_tx_in,
	input wire logic  remote_tx_in,
	output logic [1:0] mode,
	output logic      led
);
	realtime rise_t;
	realtime tx_t;
	bit      armed = 1'b0;
	initial mode = MODE_SIR;
	always @(posedge shutdown_program_in)
	begin
		rise_t = $realtime;
		armed = 1'b1;
	end
	always @(posedge irda_tx_in) tx_t = $realtime;
	// Setting moves only on the falling edge; the unknown-to-low settle at power-up is no pulse
	always @(negedge shutdown_program_in)
		if (!armed)
			mode = MODE_SIR;
		else if ($realtime - rise_t >= SHUT_NS)
			mode = MODE_SIR;
		else if (!irda_tx_in)
			mode = MODE_SIR;
		else if ($realtime - tx_t >= REMOTE_PULSE_NS)
			mode = MODE_REMOTE;
		else
			mode = MODE_FIR;
	assign led = !shutdown_program_in && (irda_tx_in ^ remote_tx_in);
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
	import ir_ctrl_pkg::*;
	localparam int unsigned SHUT_C = 60;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0]  htrans = 0, mode;
	logic [2:0]  hsize = 0;
	logic        hreadyout, hresp, shutdown_program_in, irda_tx_in, remote_tx_in, led;
	int          bad_count = 0, cmp_count = 0, cyc = 0;
	always #5 hclk = ~hclk;
	ir_ctrl #(.SHUTDOWN_CYCLES(SHUT_C)) u_dut(
		.hclk               (hclk),
		.hresetn            (hresetn),
		.hsel               (hsel),
		.haddr              (haddr),
		.htrans             (htrans),
		.hwrite             (hwrite),
		.hsize              (hsize),
		.hready             (hreadyout),
		.hwdata             (hwdata),
		.hrdata             (hrdata),
		.hreadyout          (hreadyout),
		.hresp              (hresp),
		.shutdown_program_in(shutdown_program_in),
		.irda_tx_in         (irda_tx_in),
		.remote_tx_in       (remote_tx_in)
	);
	ir_dev_model #(.SHUT_NS(SHUT_C * CLK_NS)) u_dev(
		.shutdown_program_in(shutdown_program_in),
		.irda_tx_in         (irda_tx_in),
		.remote_tx_in       (remote_tx_in),
		.mode               (mode),
		.led                (led)
	);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task prog(input logic [1:0] c, input logic [1:0] m);
		bus(1, 32'(CTRL_OFS), 32'(c) | 32'h10);
		repeat (3) @(posedge hclk);
		do bus(0, 32'(STATUS_OFS), 0); while (q[0] !== 1'b0);
		repeat (8) @(posedge hclk);
		chk(32'(mode), 32'(m));
		chk(32'(q[2:1]), 32'(m));
	endtask
	task t_reset;
		chk(32'(mode), 32'(MODE_SIR));
		bus(0, 32'(STATUS_OFS), 0);
		chk(q, 32'h0);
		bus(0, 32'h8, 0);
		chk(q, 32'h0);
		chk(32'(hresp), 32'h0);
	endtask
	task t_shut;
		prog(CMD_REMOTE, MODE_REMOTE);
		prog(CMD_SHUTDOWN, MODE_SIR);
	endtask
	task t_modes;
		prog(CMD_FIR, MODE_FIR);
		prog(CMD_SIR, MODE_SIR);
		prog(CMD_REMOTE, MODE_REMOTE);
		prog(CMD_FIR, MODE_FIR);
	endtask
	task t_pins;
		for (int i = 0; i < 4; i++)
		begin
			bus(1, 32'(CTRL_OFS), 32'h400 | (i << 8));
			repeat (3) @(posedge hclk);
			chk(32'(irda_tx_in), 32'(i & 1));
			chk(32'(remote_tx_in), 32'(i == 2));
			chk(32'(led), 32'(i != 0));
		end
		bus(1, 32'(CTRL_OFS), 32'h200);
		repeat (3) @(posedge hclk);
		chk(32'(remote_tx_in), 32'h0);
		chk(32'(mode), 32'(MODE_FIR));
		bus(0, 32'(CTRL_OFS), 0);
		chk(q, 32'h200);
		bus(0, 32'(STATUS_OFS), 0);
		chk(32'(q[2:1]), 32'(MODE_FIR));
	endtask
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			summarize;
		end
	end
	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		t_reset;
		t_shut;
		t_modes;
		t_pins;
		summarize;
	end
endmodule
bind ir_ctrl ir_ctrl_checker #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES)) u_chk(
	.hclk               (hclk),
	.hresetn            (hresetn),
	.shutdown_program_in(shutdown_program_in),
	.irda_tx_in         (irda_tx_in),
	.remote_tx_in       (remote_tx_in)
);
`default_nettype wire
